// >>> hw/uart_ctrl_status_driver_enable.v
// Purpose: uart transmitter/receiver with control/status registers and transceiver drive enable
// Assumes: one 10 mhz clock, avalon-mm slave with waitrequest, 16x oversampled baud tick
// Notes: all outputs registered; serial rx is taken as synchronous to the clock
//
// How it works
// - mode 11 filters frames, flags first byte
// - drive enable rises on data write, spans frame
// - drive enable leads start by one bit
// - drive enable drops one clock after stop
// - back to back bytes keep drive enable
// - polarity bit selects drive enable level
// - control bit 7 enables transmitter
// - cts gating holds transmitter while cts high
// - break bit forces transmit line low
// - stop count bit picks one or two
// - loopback routes transmit into receiver
// - rx available sets on byte, read clears
// - parity error sets on mismatch outside mode 11, read clears
// - overrun on unread byte, a data read while empty clears
// - framing error on bad stop, read clears
// - all-zero frame sets break seen flag
// - tx holding empty resets high, write clears
// - shift empty high when transmission finished
// - status bit 0 shows cts input level
// - first byte of frame flag, read clears
// - tx and rx data share one address
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "uart_de_defines.vh"

module uart_ctrl_status_driver_enable #(
  parameter OVS = 16 // oversampling ticks per bit
) (
  input wire I_SYS_CLK, // system clock 10 mhz
  input wire I_NRST, // async reset, active low
  input wire [11:0] I_ADDRESS, // avalon word address
  input wire I_READ, // avalon read
  input wire I_WRITE, // avalon write
  input wire [31:0] I_WRITEDATA, // avalon write data
  output reg [31:0] O_READDATA, // avalon read data
  output reg O_WAITREQUEST, // avalon wait request
  input wire I_RXD, // serial receive line
  input wire I_CTS_N, // clear to send, active low
  output reg O_TXD, // serial transmit line
  output reg O_TRANSCEIVER_DRIVE_EN // transceiver drive enable
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] ctl0_r; // control zero
reg [7:0] ctl1_r; // control one: mode, polarity
reg [7:0] addr_cmp_r; // node address
reg [15:0] baud_r; // clocks per oversample tick minus one
reg [15:0] bcnt_r; // baud divider
reg tick_r; // oversample tick pulse
reg ack_r; // bus answer phase
wire access = (I_READ | I_WRITE) & ~ack_r; // new request seen
wire wr_data = I_WRITE & ~ack_r & (I_ADDRESS == `IDX_DATA);
wire rd_data = I_READ & ~ack_r & (I_ADDRESS == `IDX_DATA);

////////////////////////////////////////////////////////////////////////////////
// baud tick divider, every serial step is a one-cycle enable
// limitation: a smaller divisor written mid-count takes hold once the count passes it
always @(posedge I_SYS_CLK or negedge I_NRST) begin
  if (!I_NRST) begin
    bcnt_r <= 16'h0000;
    tick_r <= 1'b0;
  end else if (bcnt_r >= baud_r) begin
    bcnt_r <= 16'h0000;
    tick_r <= 1'b1;
  end else begin
    bcnt_r <= bcnt_r + 16'h0001;
    tick_r <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// transmitter
localparam TX_IDLE = 3'h0; // line idle
localparam TX_LEAD = 3'h1; // drive enable setup
localparam TX_START = 3'h2; // start bit
localparam TX_DATA = 3'h3; // data bits
localparam TX_PAR = 3'h4; // parity bit
localparam TX_STOP = 3'h5; // stop bits
localparam TX_TAIL = 3'h6; // one clock hold

reg [2:0] tx_st_r; // transmit state
reg [7:0] thr_r; // holding register
reg the_r; // holding empty flag
reg [7:0] tsr_r; // shift register
reg [3:0] tx_tk_r; // ticks within bit
reg [2:0] tx_bit_r; // bit index
reg tx_par_r; // running parity
reg tx_line_r; // line before break
reg tx_wait_r; // lead waits for its first tick
wire tx_go = ctl0_r[`CZ_TX_ON] & (~ctl0_r[`CZ_CTS_GATE] | ~I_CTS_N);
// tick indices; the tick counters are four bits wide, so OVS may not exceed 16
localparam integer TK_LAST_I = OVS - 1; // last tick of a bit
localparam integer TK_MID_I = OVS / 2 - 1; // tick of the mid-bit sample
localparam [3:0] TK_LAST = TK_LAST_I[3:0]; // cut to counter width
localparam [3:0] TK_MID = TK_MID_I[3:0]; // cut to counter width
wire bit_end = tick_r & (tx_tk_r == TK_LAST); // last tick of a bit

// frame sequencer; drive enable is active in every state but idle
always @(posedge I_SYS_CLK or negedge I_NRST) begin
  if (!I_NRST) begin
    tx_st_r <= TX_IDLE;
    thr_r <= 8'h00;
    the_r <= 1'b1;
    tsr_r <= 8'h00;
    tx_tk_r <= 4'h0;
    tx_bit_r <= 3'h0;
    tx_par_r <= 1'b0;
    tx_line_r <= 1'b1;
    tx_wait_r <= 1'b0;
  end else begin
    if (wr_data) begin
      thr_r <= I_WRITEDATA[7:0];
      the_r <= 1'b0;
    end
    // the first tick after entering the lead only arms the count, so the
    // lead is never shorter than one full bit whatever the tick phase
    if (tick_r)
      tx_wait_r <= 1'b0;
    if (tick_r && !tx_wait_r && tx_st_r != TX_IDLE && tx_st_r != TX_TAIL)
      tx_tk_r <= tx_tk_r + 4'h1;
    case (tx_st_r)
      TX_IDLE: begin
        tx_line_r <= 1'b1;
        if (wr_data || !the_r) begin
          tx_st_r <= TX_LEAD;
          tx_tk_r <= 4'h0;
          tx_wait_r <= 1'b1;
        end
      end
      TX_LEAD: begin
        // one full bit of setup, then wait for the transmitter enable
        if (bit_end && tx_go) begin
          tx_st_r <= TX_START;
          tsr_r <= thr_r;
          the_r <= wr_data ? 1'b0 : 1'b1; // write in this cycle wins
          tx_par_r <= ctl0_r[`CZ_PARITY_ODD];
          tx_line_r <= 1'b0;
        end
      end
      TX_START: begin
        if (bit_end) begin
          tx_st_r <= TX_DATA;
          tx_bit_r <= 3'h0;
          tx_line_r <= tsr_r[0];
        end
      end
      TX_DATA: begin
        if (bit_end) begin
          tx_par_r <= tx_par_r ^ tsr_r[0];
          tsr_r <= {1'b0, tsr_r[7:1]};
          tx_bit_r <= tx_bit_r + 3'h1;
          if (tx_bit_r == 3'h7) begin
            if (ctl0_r[`CZ_PARITY_ON]) begin
              tx_st_r <= TX_PAR;
              tx_line_r <= tx_par_r ^ tsr_r[0];
            end else begin
              tx_st_r <= TX_STOP;
              tx_line_r <= 1'b1;
            end
            tx_bit_r <= 3'h0;
          end else begin
            tx_line_r <= tsr_r[1];
          end
        end
      end
      TX_PAR: begin
        if (bit_end) begin
          tx_st_r <= TX_STOP;
          tx_line_r <= 1'b1;
        end
      end
      TX_STOP: begin
        if (bit_end) begin
          if (ctl0_r[`CZ_TWO_STOP] && tx_bit_r == 3'h0) begin
            tx_bit_r <= 3'h1;
          end else begin
            tx_st_r <= TX_TAIL;
          end
        end
      end
      TX_TAIL: begin
        // next byte already waiting: keep drive enable and start again
        if (!the_r || wr_data) begin
          tx_st_r <= TX_LEAD;
          tx_tk_r <= 4'h0;
          tx_wait_r <= 1'b1;
        end else begin
          tx_st_r <= TX_IDLE;
        end
      end
      default: tx_st_r <= TX_IDLE;
    endcase
  end
end

// output pins, polarity applied in the flop; drive enable follows the
// sequencer one clock late, so the tail state keeps it on for the clock
// after the last stop bit and a queued byte never lets it drop
always @(posedge I_SYS_CLK or negedge I_NRST) begin
  if (!I_NRST) begin
    O_TXD <= 1'b1;
    O_TRANSCEIVER_DRIVE_EN <= 1'b0;
  end else begin
    O_TXD <= tx_line_r & ~ctl0_r[`CZ_BREAK];
    O_TRANSCEIVER_DRIVE_EN <= ((tx_st_r != TX_IDLE) ^ ctl1_r[`C1_DE_POL]);
  end
end

////////////////////////////////////////////////////////////////////////////////
// receiver
localparam RX_IDLE = 2'h0; // waiting for start
localparam RX_BITS = 2'h1; // sampling bits
localparam RX_DONE = 2'h2; // frame end
localparam RX_HUNT = 2'h3; // bad stop, wait for idle line

reg [1:0] rx_st_r; // receive state
reg [3:0] rx_tk_r; // ticks within bit
reg [3:0] rx_n_r; // bits sampled after start
reg [8:0] rx_sh_r; // data plus parity
reg rx_zero_r; // every bit so far zero
reg [7:0] rdr_r; // receive data register
reg rda_r, pe_r, oe_r, fe_r, brk_r; // status flags
reg first_byte_of_frame_flag_r, last_multiproc_bit_rx_r; // second status flags
reg addr_ok_r; // frame addressed to us
reg next_first_r; // next data byte opens a frame
wire rx_in = ctl0_r[`CZ_LOOPBACK] ? O_TXD : I_RXD;
wire [3:0] rx_len = ctl0_r[`CZ_PARITY_ON] ? 4'h9 : 4'h8;
wire mp_mode = (ctl1_r[`C1_MP_HI:`C1_MP_LO] == `MP_MODE_FILTER);
wire rx_par = ^rx_sh_r[7:0] ^ ctl0_r[`CZ_PARITY_ODD];
wire rx_mid = tick_r & (rx_tk_r == TK_MID); // mid-bit sample point

// frame sampler, mid-bit sampling from the start edge
// no false-start check: a low glitch on a tick opens a frame
always @(posedge I_SYS_CLK or negedge I_NRST) begin
  if (!I_NRST) begin
    rx_st_r <= RX_IDLE;
    rx_tk_r <= 4'h0;
    rx_n_r <= 4'h0;
    rx_sh_r <= 9'h000;
    rx_zero_r <= 1'b0;
  end else begin
    if (tick_r)
      rx_tk_r <= (rx_st_r == RX_IDLE) ? 4'h0 : rx_tk_r + 4'h1;
    case (rx_st_r)
      RX_IDLE: begin
        if (ctl0_r[`CZ_RX_ON] && !rx_in && tick_r) begin
          rx_st_r <= RX_BITS;
          rx_n_r <= 4'h0;
          rx_zero_r <= 1'b1;
        end
      end
      RX_BITS: begin
        if (rx_mid) begin
          if (rx_n_r != 4'h0)
            rx_sh_r <= {rx_in, rx_sh_r[8:1]};
          rx_zero_r <= rx_zero_r & ~rx_in;
          rx_n_r <= rx_n_r + 4'h1;
          if (rx_n_r == rx_len)
            rx_st_r <= RX_DONE;
        end
      end
      RX_DONE: begin
        // a low stop sample means the line may still be low: hunting for a
        // start there would take the rest of a break for a new frame
        if (rx_mid)
          rx_st_r <= rx_in ? RX_IDLE : RX_HUNT; // stop bit sampled
        rx_zero_r <= rx_zero_r;
      end
      RX_HUNT: begin
        if (rx_in)
          rx_st_r <= RX_IDLE; // line back at idle level
      end
      default: rx_st_r <= RX_IDLE;
    endcase
  end
end

// frame end: stop sample is rx_in at rx_mid in done state
wire rx_end = (rx_st_r == RX_DONE) & rx_mid;
wire [7:0] rx_byte = ctl0_r[`CZ_PARITY_ON] ? rx_sh_r[7:0] : rx_sh_r[8:1];
wire rx_mpbit = ctl0_r[`CZ_PARITY_ON] ? rx_sh_r[8] : 1'b0; // address marker bit
// the address marker travels in the parity slot, so mode 11 needs parity on
wire is_addr = mp_mode & rx_mpbit;
wire deliver = rx_end & ~is_addr & (~mp_mode | addr_ok_r);

// status flags; a set in the same cycle as the read clear wins
always @(posedge I_SYS_CLK or negedge I_NRST) begin
  if (!I_NRST) begin
    rdr_r <= 8'h00;
    rda_r <= 1'b0;
    pe_r <= 1'b0;
    oe_r <= 1'b0;
    fe_r <= 1'b0;
    brk_r <= 1'b0;
    first_byte_of_frame_flag_r <= 1'b0;
    last_multiproc_bit_rx_r <= 1'b0;
    addr_ok_r <= 1'b0;
    next_first_r <= 1'b0;
  end else begin
    if (rd_data) begin
      rda_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      brk_r <= 1'b0;
      first_byte_of_frame_flag_r <= 1'b0;
      last_multiproc_bit_rx_r <= 1'b0;
      if (!rda_r)
        oe_r <= 1'b0;
    end
    if (rx_end && is_addr) begin
      // address byte: no delivery, just open or close the frame
      addr_ok_r <= (rx_byte == addr_cmp_r);
      next_first_r <= (rx_byte == addr_cmp_r);
    end
    if (deliver) begin
      rdr_r <= rx_byte;
      rda_r <= 1'b1;
      last_multiproc_bit_rx_r <= rx_mpbit;
      first_byte_of_frame_flag_r <= mp_mode & next_first_r;
      next_first_r <= 1'b0;
      if (rda_r && !rd_data)
        oe_r <= 1'b1;
      pe_r <= ctl0_r[`CZ_PARITY_ON] & (rx_par != rx_sh_r[8]) & ~mp_mode;
      fe_r <= ~rx_in;
      brk_r <= rx_zero_r & ~rx_in;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait state, answer at the second edge of a request
always @(posedge I_SYS_CLK or negedge I_NRST) begin
  if (!I_NRST) begin
    ctl0_r <= `RST_CONTROL_ZERO;
    ctl1_r <= `RST_CONTROL_ONE;
    addr_cmp_r <= `RST_ADDR_CMP;
    baud_r <= `RST_BAUD;
    ack_r <= 1'b0;
    O_WAITREQUEST <= 1'b1;
    O_READDATA <= 32'h0000_0000;
  end else begin
    // writes land at the take edge; the answer stands one clock later
    ack_r <= access;
    O_WAITREQUEST <= ~access;
    if (I_WRITE && !ack_r) begin
      case (I_ADDRESS)
        `IDX_CONTROL_ZERO: ctl0_r <= I_WRITEDATA[7:0];
        `IDX_CONTROL_ONE: ctl1_r <= I_WRITEDATA[7:0];
        `IDX_ADDR_CMP: addr_cmp_r <= I_WRITEDATA[7:0];
        `IDX_BAUD: baud_r <= I_WRITEDATA[15:0];
        default: ;
      endcase
    end
    if (I_READ && !ack_r) begin
      case (I_ADDRESS)
        `IDX_DATA: O_READDATA <= {24'h0, rdr_r};
        `IDX_STATUS_ZERO: O_READDATA <= {24'h0, rda_r, pe_r, oe_r, fe_r, brk_r,
          the_r, (the_r && tx_st_r == TX_IDLE), I_CTS_N};
        `IDX_CONTROL_ZERO: O_READDATA <= {24'h0, ctl0_r};
        `IDX_CONTROL_ONE: O_READDATA <= {24'h0, ctl1_r};
        `IDX_STATUS_ONE: O_READDATA <= {30'h0, first_byte_of_frame_flag_r, last_multiproc_bit_rx_r};
        `IDX_ADDR_CMP: O_READDATA <= {24'h0, addr_cmp_r};
        `IDX_BAUD: O_READDATA <= {16'h0, baud_r};
        default: O_READDATA <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end
end

endmodule // uart_ctrl_status_driver_enable

// >>> include/uart_de_defines.vh
// Purpose: register offsets, field positions and reset values of the uart block
// Assumes: avalon-mm word addressing, one register of up to 16 bits per 32-bit word
// Notes: printed offsets run one apart, not four, so they act as word indices
`ifndef UART_DE_DEFINES_VH
`define UART_DE_DEFINES_VH

// register indices (byte address is four times the index)
`define IDX_STATUS_ZERO 12'hf41
`define IDX_CONTROL_ZERO 12'hf42
`define IDX_DATA 12'hf40
`define IDX_CONTROL_ONE 12'hf43
`define IDX_STATUS_ONE 12'hf44
`define IDX_ADDR_CMP 12'hf45
`define IDX_BAUD 12'hf46

// control zero fields
`define CZ_TX_ON 7
`define CZ_RX_ON 6
`define CZ_CTS_GATE 5
`define CZ_PARITY_ON 4
`define CZ_PARITY_ODD 3
`define CZ_BREAK 2
`define CZ_TWO_STOP 1
`define CZ_LOOPBACK 0

// control one fields
`define C1_MP_LO 0
`define C1_MP_HI 1
`define C1_DE_POL 2

// status zero fields
`define SZ_RDA 7
`define SZ_PE 6
`define SZ_OE 5
`define SZ_FE 4
`define SZ_BRK 3
`define SZ_THE 2
`define SZ_TSE 1
`define SZ_CTS 0

// status one fields
`define S1_FIRST_BYTE_OF_FRAME_FLAG 1
`define S1_LAST_MULTIPROC_BIT_RX 0

// reset values
`define RST_CONTROL_ZERO 8'h00
`define RST_CONTROL_ONE 8'h00
`define RST_ADDR_CMP 8'h00
`define RST_BAUD 16'h0004

// multiprocessor mode with filtering and no address interrupts
`define MP_MODE_FILTER 2'h3

`endif

// >>> tb/uart_ctrl_status_driver_enable_bench.sv
// Purpose: self-checking bench for the uart block
// Assumes: divisor 0, so a bit is 16 clocks
// Notes: all register traffic uses one avalon task
`include "uart_de_defines.vh"
module uart_ctrl_status_driver_enable_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, cts_n = 1'b1; // driven
  logic [11:0] addr = 12'h000; // register index
  logic [31:0] wdata = 32'h0, rdata; // bus data
  logic waitreq, txd, de, rxd; // watched
  int n_errors = 0, n_checks = 0, cyc = 0; // counts
  always #50 clk = ~clk;
  uart_ctrl_status_driver_enable dut_u (.I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDRESS(addr),
    .I_READ(rd), .I_WRITE(wr), .I_WRITEDATA(wdata), .O_READDATA(rdata),
    .O_WAITREQUEST(waitreq), .I_RXD(rxd), .I_CTS_N(cts_n), .O_TXD(txd),
    .O_TRANSCEIVER_DRIVE_EN(de));
  uart_remote_node node_u (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
  ////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  // one avalon access; held until wait request is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int t;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (waitreq !== 1'b0 && t < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (t == 20) chk(0, 1);
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  // poll status until bit b is set, bounded
  task automatic poll(input int b);
    logic [31:0] q;
    int t;
    for (t = 0; t < 200; t++) begin
      bus(1'b0, `IDX_STATUS_ZERO, 8'h00, q);
      if (q[b] === 1'b1) break;
    end
    chk(t < 200, 1);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rchk(`IDX_STATUS_ZERO, 8'h07);
    rchk(`IDX_CONTROL_ZERO, 8'h00);
    rchk(12'hf47, 8'h00);
    wreg(`IDX_BAUD, 8'h00);
  endtask
  // even parity, two stops: lead and tail of the drive enable
  task automatic t_frame;
    int n;
    int lead;
    wreg(`IDX_CONTROL_ZERO, 8'h92);
    wreg(`IDX_DATA, 8'ha5);
    lead = 0;
    for (n = 0; n < 200 && txd; n++) begin
      lead += de;
      @(posedge clk);
    end
    chk(lead >= 16 && lead <= 32, 1);
    for (n = 0; n < 400 && de; n++) @(posedge clk);
    chk(n, 193);
    chk(node_u.got_r, 8'ha5);
    chk(node_u.par_r, 0);
    rchk(`IDX_STATUS_ZERO, 8'h07);
  endtask
  // odd parity, second byte queued while the first is on the line
  task automatic t_b2b;
    int n;
    int gaps;
    logic [31:0] q;
    n = node_u.n_got;
    wreg(`IDX_CONTROL_ZERO, 8'h98);
    wreg(`IDX_DATA, 8'h3c);
    poll(2);
    wreg(`IDX_DATA, 8'h5a);
    bus(1'b0, `IDX_STATUS_ZERO, 8'h00, q);
    chk(q[1], 0);
    gaps = 0;
    for (int i = 0; i < 1000 && node_u.n_got < n + 2; i++) begin
      gaps += !de;
      @(posedge clk);
    end
    chk(gaps, 0);
    chk(node_u.got_r, 8'h5a);
    chk(node_u.par_r, 1);
  endtask
  // cts gating, polarity and break
  task automatic t_gate;
    int lows;
    logic [31:0] q;
    wreg(`IDX_CONTROL_ZERO, 8'ha0);
    wreg(`IDX_DATA, 8'h11);
    lows = 0;
    repeat (100) begin
      lows += !txd;
      @(posedge clk);
    end
    chk(lows, 0);
    cts_n <= 1'b0;
    bus(1'b0, `IDX_STATUS_ZERO, 8'h00, q);
    chk(q[0], 0);
    poll(1);
    chk(node_u.got_r, 8'h11);
    repeat (40) @(posedge clk);
    wreg(`IDX_CONTROL_ONE, 8'h04);
    @(posedge clk);
    chk(de, 1);
    wreg(`IDX_CONTROL_ONE, 8'h00);
    wreg(`IDX_CONTROL_ZERO, 8'h84);
    @(posedge clk);
    chk(txd, 0);
    cts_n <= 1'b1;
    wreg(`IDX_CONTROL_ZERO, 8'h80);
    @(posedge clk);
    chk(txd, 1);
    repeat (200) @(posedge clk);
  endtask
  // good, bad parity, bad stop, break, receiver off; then overrun
  task automatic t_rx;
    logic [7:0] ctl [5] = '{8'h50, 8'h50, 8'h50, 8'h50, 8'h10};
    logic [8:0] bits [5] = '{9'h03c, 9'h13c, 9'h03c, 9'h000, 9'h03c};
    logic stp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] st [5] = '{8'h87, 8'hc7, 8'h97, 8'h9f, 8'h07};
    logic [31:0] q;
    for (int i = 0; i < 5; i++) begin
      wreg(`IDX_CONTROL_ZERO, ctl[i]);
      node_u.send(bits[i], stp[i]);
      rchk(`IDX_STATUS_ZERO, st[i]);
      if (st[i][7]) rchk(`IDX_DATA, bits[i][7:0]);
      rchk(`IDX_STATUS_ZERO, 8'h07);
    end
    wreg(`IDX_CONTROL_ZERO, 8'h50);
    node_u.send(9'h03c, 1'b1);
    node_u.send(9'h03c, 1'b1);
    rchk(`IDX_STATUS_ZERO, 8'ha7);
    rchk(`IDX_DATA, 8'h3c);
    rchk(`IDX_STATUS_ZERO, 8'h27);
    bus(1'b0, `IDX_DATA, 8'h00, q);
    rchk(`IDX_STATUS_ZERO, 8'h07);
    wreg(`IDX_CONTROL_ZERO, 8'hc1);
    wreg(`IDX_DATA, 8'h69);
    poll(7);
    rchk(`IDX_DATA, 8'h69);
  endtask
  // address filter: a matching address opens a frame, any other closes it
  task automatic t_mp;
    wreg(`IDX_CONTROL_ONE, 8'h03);
    wreg(`IDX_ADDR_CMP, 8'h42);
    wreg(`IDX_CONTROL_ZERO, 8'h50);
    node_u.send(9'h142, 1'b1);
    rchk(`IDX_STATUS_ZERO, 8'h07);
    node_u.send(9'h055, 1'b1);
    rchk(`IDX_STATUS_ZERO, 8'h87);
    rchk(`IDX_STATUS_ONE, 8'h02);
    rchk(`IDX_DATA, 8'h55);
    rchk(`IDX_STATUS_ONE, 8'h00);
    node_u.send(9'h066, 1'b1);
    rchk(`IDX_STATUS_ONE, 8'h00);
    rchk(`IDX_DATA, 8'h66);
    node_u.send(9'h143, 1'b1);
    node_u.send(9'h077, 1'b1);
    rchk(`IDX_STATUS_ZERO, 8'h07);
    wreg(`IDX_CONTROL_ONE, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_frame();
    t_b2b();
    t_gate();
    t_rx();
    t_mp();
    final_report();
  end
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
endmodule // uart_ctrl_status_driver_enable_bench

// >>> tb/uart_de_props.sv
// Purpose: port-level checks on the uart block
// Assumes: software writes registers over avalon
// Notes: copies take each write at its answer edge
`include "uart_de_defines.vh"
module uart_de_props #(
  parameter OVS = 16 // ticks per bit
) (
  input wire I_SYS_CLK, // clock
  input wire I_NRST, // reset, active low
  input wire [11:0] I_ADDRESS,
  input wire I_READ,
  input wire I_WRITE,
  input wire [31:0] I_WRITEDATA,
  input wire [31:0] O_READDATA,
  input wire O_WAITREQUEST,
  input wire I_RXD,
  input wire I_CTS_N,
  input wire O_TXD,
  input wire O_TRANSCEIVER_DRIVE_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] c0_r; // control zero copy
  reg pol_r; // polarity copy
  reg [15:0] baud_r; // divisor copy
  reg [15:0] de_cnt_r; // cycles drive active
  wire wr_ok = I_WRITE && !O_WAITREQUEST; // write answered
  wire de_on = O_TRANSCEIVER_DRIVE_EN ^ pol_r; // active, any level
  wire [15:0] bit_len = 16'(OVS) * (baud_r + 16'h0001); // clocks a bit
  ////////////////////////////////////////
  // copies change at the same edge as the block's outputs
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      c0_r <= 8'h00;
      pol_r <= 1'b0;
      baud_r <= `RST_BAUD;
      de_cnt_r <= 16'h0000;
    end else begin
      if (wr_ok && I_ADDRESS == `IDX_CONTROL_ZERO) c0_r <= I_WRITEDATA[7:0];
      if (wr_ok && I_ADDRESS == `IDX_CONTROL_ONE) pol_r <= I_WRITEDATA[2];
      if (wr_ok && I_ADDRESS == `IDX_BAUD) baud_r <= I_WRITEDATA[15:0];
      // saturate so a long idle drive never wraps
      de_cnt_r <= !de_on ? 16'h0000 : (&de_cnt_r ? de_cnt_r : de_cnt_r + 16'h0001);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  property p_ack_once; $fell(O_WAITREQUEST) |=> O_WAITREQUEST; endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer too long");
  property p_ack_due; (I_READ || I_WRITE) && O_WAITREQUEST |=> !O_WAITREQUEST; endproperty
  a_ack_due: assert property (p_ack_due) else $error("no answer");
  property p_cts_bit; I_READ && O_WAITREQUEST && I_ADDRESS == `IDX_STATUS_ZERO
    |=> O_READDATA[0] == $past(I_CTS_N); endproperty
  a_cts_bit: assert property (p_cts_bit) else $error("cts bit wrong");
  property p_break; c0_r[2] && $past(c0_r[2]) |-> !O_TXD; endproperty
  a_break: assert property (p_break) else $error("break not low");
  property p_lead; $fell(O_TXD) && !c0_r[2] |-> de_cnt_r >= bit_len - 16'h0001; endproperty
  a_lead: assert property (p_lead) else $error("drive lead short");
  property p_quiet; !de_on && !c0_r[2] && !$past(c0_r[2]) |-> O_TXD; endproperty
  a_quiet: assert property (p_quiet) else $error("data without drive");
  property p_tx_off; !c0_r[7] && !$past(c0_r[7]) && $past(O_TXD) && !c0_r[2]
    |-> O_TXD; endproperty
  a_tx_off: assert property (p_tx_off) else $error("sent while off");
  property p_cts_hold; c0_r[5] && I_CTS_N && $past(I_CTS_N) && $past(O_TXD)
    && !c0_r[2] |-> O_TXD; endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("sent while gated");
  c_start: cover property ($fell(O_TXD) && de_on);
  c_break: cover property (c0_r[2] && !O_TXD);
  c_rx: cover property (O_READDATA[7]);
endmodule // uart_de_props

bind uart_ctrl_status_driver_enable uart_de_props #(.OVS(OVS)) props_u (.*);

// >>> tb/uart_remote_node.sv
// Purpose: remote serial node beyond the transceiver
// Assumes: one bit lasts 16 clocks
// Notes: line is biased high between frames
module uart_remote_node (
  input wire logic i_clk, // system clock
  input wire logic i_txd, // line from the block
  output logic o_rxd // line into the block
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_r = 8'h00; // last byte heard
  logic par_r = 1'b0; // bit after the data
  int n_got = 0; // frames heard
  initial o_rxd = 1'b1;
  // hear a frame at mid-bit; then wait out a low bit nine
  always begin
    @(negedge i_txd);
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge i_clk);
      if (i < 8) got_r[i] = i_txd;
      else par_r = i_txd;
    end
    n_got++;
    wait (i_txd);
  end
  // start, nine bits, stop, then one idle bit
  task automatic send(input logic [8:0] b, input logic stp);
    for (int i = 0; i < 12; i++) begin
      o_rxd <= i == 0 ? 1'b0 : i < 10 ? b[i-1] : i == 10 ? stp : 1'b1;
      repeat (16) @(posedge i_clk);
    end
  endtask
endmodule // uart_remote_node
